// file: design/cvc_ctrl.sv
// Converter control register pair with sleep-pin mode decoding
// Assumes a host register port on i_sys_clk and static strap pins
`timescale 1ns/1ns
`default_nettype none
`include "cvc_regs.svh"

module cvc_ctrl (
    input  wire logic       i_sys_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    output logic      [7:0] o_reg_rdata,
    output logic            o_reg_hit,
    input  wire logic       i_sleep_request_pin,
    input  wire logic       i_io_rail_default_strap,
    input  wire logic       i_proc_rail_default_strap,
    output logic            o_forced_pwm,
    output logic      [1:0] o_undervoltage_threshold_sel,
    output logic      [1:0] o_io_rail_voltage_sel,
    output logic            o_io_rail_en,
    output logic            o_io_rail_discharge,
    output logic      [2:0] o_proc_rail_voltage_code,
    output logic            o_proc_rail_en,
    output logic            o_proc_rail_discharge,
    output logic            o_motor_driver_en,
    output logic            o_wait_mode,
    output logic            o_lowpower_mode
);
    logic [7:0]       io_converter_control;
    logic [7:0]       proc_converter_control;
    logic             sleep_req;
    logic             io_strap;
    logic             pr_strap;
    logic             strap_loaded;
    cvc_pkg::cvc_mode_t mode;
    cvc_pkg::cvc_mode_t next_mode;
    logic [2:0]       eff_code;

    // Sleep pin and straps pass two flops before use
    cvc_sync u_sync_sleep (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   (i_sleep_request_pin),
        .o_sync    (sleep_req)
    );
    cvc_sync u_sync_io_strap (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   (i_io_rail_default_strap),
        .o_sync    (io_strap)
    );
    cvc_sync u_sync_pr_strap (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   (i_proc_rail_default_strap),
        .o_sync    (pr_strap)
    );

    // Address decode shared by reads and writes
    function automatic logic [1:0] decode(input logic [7:0] addr);
        decode = {addr == `CVC_PROC_CTRL_OFFSET,
                  addr == `CVC_IO_CTRL_OFFSET};
    endfunction

    // Decoded selects, so no bit is picked off a call result
    logic [1:0] wr_sel;
    logic [1:0] rd_sel;
    assign wr_sel = decode(i_reg_addr) & {2{i_reg_wr}};
    assign rd_sel = decode(i_reg_addr);

    // Straps are caught once, on the third rising edge after reset release
    logic [1:0] strap_wait;
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            strap_wait   <= 2'h0;
            strap_loaded <= 1'b0;
        end else begin
            if (strap_wait != 2'h2) begin
                strap_wait <= strap_wait + 2'h1;
            end
            strap_loaded <= (strap_wait == 2'h2);
        end
    end

    // Peripheral-rail control register
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            io_converter_control <= `CVC_IO_RESET_BASE;
        end else if (wr_sel[0]) begin
            io_converter_control <= i_reg_wdata;
        end else if (!strap_loaded && strap_wait == 2'h2) begin
            io_converter_control[`CVC_IO_VSEL_LO] <= io_strap;
        end
    end

    // Processor-rail control register
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            proc_converter_control <= `CVC_PR_RESET_BASE & ~8'h10;
        end else if (wr_sel[1]) begin
            proc_converter_control <= i_reg_wdata;
        end else if (!strap_loaded && strap_wait == 2'h2) begin
            proc_converter_control[`CVC_PR_STRAP_BIT] <= pr_strap;
        end
    end

    // Read data registered; unmapped addresses read zero
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_reg_rdata <= 8'h00;
            o_reg_hit   <= 1'b0;
        end else if (i_reg_rd) begin
            o_reg_hit <= |rd_sel;
            case (rd_sel)
                2'h1:    o_reg_rdata <= io_converter_control;
                2'h2:    o_reg_rdata <= proc_converter_control;
                default: o_reg_rdata <= 8'h00;
            endcase
        end
    end

    // Mode decode from the synchronised sleep pin
    always_comb begin
        next_mode = cvc_pkg::CVC_RUN;
        if (sleep_req && io_converter_control[`CVC_IO_SLPEN_BIT]) begin
            if (io_converter_control[`CVC_IO_LPSEL_BIT]) begin
                next_mode = cvc_pkg::CVC_LP;
            end else begin
                next_mode = cvc_pkg::CVC_WAIT;
            end
        end
    end

    // Mode register
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            mode <= cvc_pkg::CVC_RUN;
        end else begin
            case (next_mode)
                cvc_pkg::CVC_RUN,
                cvc_pkg::CVC_WAIT,
                cvc_pkg::CVC_LP: mode <= next_mode;
                default:         mode <= cvc_pkg::CVC_RUN;
            endcase
        end
    end

    cvc_rail_code u_rail_code (
        .i_full_code  (proc_converter_control[`CVC_PR_CODE_HI:`CVC_PR_CODE_LO]),
        .i_sleep_code (proc_converter_control[`CVC_PR_SLP_HI:`CVC_PR_SLP_LO]),
        .i_lowpower   (next_mode == cvc_pkg::CVC_LP),
        .o_code       (eff_code)
    );

    // Converter control outputs, all registered
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_forced_pwm                 <= 1'b0;
            o_undervoltage_threshold_sel <= 2'h0;
            o_io_rail_voltage_sel        <= 2'h2;
            o_io_rail_en                 <= 1'b1;
            o_io_rail_discharge          <= 1'b0;
            o_proc_rail_voltage_code     <= 3'h6;
            o_proc_rail_en               <= 1'b1;
            o_proc_rail_discharge        <= 1'b0;
            o_motor_driver_en            <= 1'b0;
            o_wait_mode                  <= 1'b0;
            o_lowpower_mode              <= 1'b0;
        end else begin
            o_forced_pwm <= io_converter_control[`CVC_IO_FORCED_PWM_BIT];
            o_undervoltage_threshold_sel <=
                io_converter_control[`CVC_IO_UVLO_HI:`CVC_IO_UVLO_LO];
            o_io_rail_voltage_sel <=
                io_converter_control[`CVC_IO_VSEL_HI:`CVC_IO_VSEL_LO];
            o_io_rail_en <= (next_mode != cvc_pkg::CVC_WAIT);
            o_io_rail_discharge <= (next_mode == cvc_pkg::CVC_WAIT)
                && io_converter_control[`CVC_IO_DISCH_BIT];
            o_proc_rail_voltage_code <= eff_code;
            o_proc_rail_en <= !((next_mode == cvc_pkg::CVC_WAIT) ||
                ((next_mode == cvc_pkg::CVC_LP) &&
                 proc_converter_control[`CVC_PR_COREOFF_BIT]));
            o_proc_rail_discharge <=
                proc_converter_control[`CVC_PR_DISCH_BIT] &&
                ((next_mode == cvc_pkg::CVC_WAIT) ||
                 ((next_mode == cvc_pkg::CVC_LP) &&
                  proc_converter_control[`CVC_PR_COREOFF_BIT]));
            o_motor_driver_en <=
                proc_converter_control[`CVC_PR_MOTOR_BIT];
            o_wait_mode     <= (next_mode == cvc_pkg::CVC_WAIT);
            o_lowpower_mode <= (next_mode == cvc_pkg::CVC_LP);
        end
    end
endmodule // cvc_ctrl
`default_nettype wire

// file: design/cvc_pkg.sv
// Types shared by the converter control block
// Assumes the register header supplies all register numbers; mode encodings are set here
package cvc_pkg;
    typedef enum logic [2:0] {
        CVC_RUN  = 3'h1,
        CVC_WAIT = 3'h2,
        CVC_LP   = 3'h4
    } cvc_mode_t;
endpackage

// file: design/cvc_rail_code.sv
// Effective processor-rail code selection for run and low-power modes
// Assumes a mode decoded from registered signals and registered field values on the same clock
`timescale 1ns/1ns
`default_nettype none
module cvc_rail_code (
    input  wire logic [2:0] i_full_code,
    input  wire logic [1:0] i_sleep_code,
    input  wire logic       i_lowpower,
    output logic      [2:0] o_code
);
    // Low power forces the top bit low and takes the sleep code below it
    always_comb begin
        if (i_lowpower) begin
            o_code = {1'b0, i_sleep_code};
        end else begin
            o_code = i_full_code;
        end
    end
endmodule // cvc_rail_code
`default_nettype wire

// file: design/cvc_regs.svh
// Register offsets, field positions, reset values for the converter controls
// Assumes inclusion by any file that touches the two control registers
`ifndef CVC_REGS_SVH
`define CVC_REGS_SVH

`define CVC_ADDR_W            8
`define CVC_IO_CTRL_OFFSET    8'h0C
`define CVC_PROC_CTRL_OFFSET  8'h0D

// Peripheral-rail control fields
`define CVC_IO_FORCED_PWM_BIT       7
`define CVC_IO_UVLO_HI        6
`define CVC_IO_UVLO_LO        5
`define CVC_IO_LPSEL_BIT      4
`define CVC_IO_SLPEN_BIT      3
`define CVC_IO_DISCH_BIT      2
`define CVC_IO_VSEL_HI        1
`define CVC_IO_VSEL_LO        0
// Reset 32h or 33h; strap lands in bit 0
`define CVC_IO_RESET_BASE     8'h32

// Processor-rail control fields
`define CVC_PR_COREOFF_BIT    7
`define CVC_PR_CODE_HI        6
`define CVC_PR_CODE_LO        4
`define CVC_PR_SLP_HI         3
`define CVC_PR_SLP_LO         2
`define CVC_PR_MOTOR_BIT      1
`define CVC_PR_DISCH_BIT      0
// Reset 68h or 78h; strap lands in bit 4
`define CVC_PR_RESET_BASE     8'h68
`define CVC_PR_STRAP_BIT      4

`endif

// file: design/cvc_sync.sv
// Two-flop synchroniser for a level arriving from a pin
// Assumes the input is a slow static or quasi-static level
`timescale 1ns/1ns
`default_nettype none
module cvc_sync (
    input  wire logic i_sys_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_async,
    output logic      o_sync
);
    logic stage1;

    // First stage read only by the second
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            stage1 <= 1'b0;
            o_sync <= 1'b0;
        end else begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end
endmodule // cvc_sync
`default_nettype wire

// file: sim/cvc_checker.sv
// Concurrent checks on the converter control block ports
// Assumes a bind onto cvc_ctrl, one clock, synchronous reset
`timescale 1ns/1ns
`default_nettype none
module cvc_checker (
    input wire logic       i_sys_clk,
    input wire logic       i_sys_rst,
    input wire logic       i_reg_wr,
    input wire logic       i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic       o_reg_hit,
    input wire logic       o_forced_pwm,
    input wire logic [1:0] o_undervoltage_threshold_sel,
    input wire logic       o_io_rail_en,
    input wire logic       o_io_rail_discharge,
    input wire logic [2:0] o_proc_rail_voltage_code,
    input wire logic       o_proc_rail_discharge,
    input wire logic       o_motor_driver_en,
    input wire logic       o_wait_mode,
    input wire logic       o_lowpower_mode
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    // Host accesses that start a checked behaviour
    sequence s_io_wr; i_reg_wr && i_reg_addr == 8'h0C; endsequence
    sequence s_pr_wr; i_reg_wr && i_reg_addr == 8'h0D; endsequence
    sequence s_bad_rd;
        i_reg_rd && i_reg_addr != 8'h0C && i_reg_addr != 8'h0D;
    endsequence
    // Field writes reach outputs two edges later
    AST_FORCED_PWM: assert property (s_io_wr |-> ##2
        o_forced_pwm == $past(i_reg_wdata[7], 2)) else $error("pwm");
    AST_UVSEL: assert property (s_io_wr |-> ##2
        o_undervoltage_threshold_sel == $past(i_reg_wdata[6:5], 2))
        else $error("uv sel");
    AST_MOTOR: assert property (s_pr_wr |-> ##2
        o_motor_driver_en == $past(i_reg_wdata[1], 2)) else $error("motor");
    AST_UNMAP: assert property (s_bad_rd |=>
        !o_reg_hit && o_reg_rdata == 8'h00) else $error("unmapped read");
    // Mode relations between outputs
    AST_LPCODE: assert property (o_lowpower_mode |->
        !o_proc_rail_voltage_code[2]) else $error("lp code");
    AST_MODES: assert property (!(o_wait_mode && o_lowpower_mode))
        else $error("two modes");
    AST_WAITOFF: assert property (o_wait_mode |-> !o_io_rail_en)
        else $error("io on in wait");
    AST_IODIS: assert property (o_io_rail_discharge |-> !o_io_rail_en)
        else $error("io discharge while on");
    AST_PDIS: assert property (o_proc_rail_discharge |->
        o_wait_mode || o_lowpower_mode) else $error("proc discharge");
endmodule // cvc_checker
`default_nettype wire

// file: sim/cvc_ctrl_test.sv
// Self-checking bench for the converter control register pair
// Assumes cvc_ctrl, cvc_host and cvc_checker are compiled first
`timescale 1ns/1ns
`default_nettype none
`include "cvc_regs.svh"
module cvc_ctrl_test;
    logic       clk, rst, wr, rd, pin, ios, prs, hit, forced_pwm, io_en, io_dis;
    logic       pr_en, pr_dis, motor, wt, lp;
    logic [7:0] addr, wdata, rdata, d;
    logic [1:0] uv, io_sel;
    logic [2:0] code;
    logic       h;
    int         error_cnt, cmp_count, cyc;
    cvc_host i_cvc_host (.i_sys_clk(clk), .i_reg_rdata(rdata),
        .i_reg_hit(hit), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr),
        .o_reg_wdata(wdata));
    cvc_ctrl i_cvc_ctrl (.i_sys_clk(clk), .i_sys_rst(rst), .i_reg_wr(wr),
        .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .o_reg_hit(hit), .i_sleep_request_pin(pin),
        .i_io_rail_default_strap(ios), .i_proc_rail_default_strap(prs),
        .o_forced_pwm(forced_pwm), .o_undervoltage_threshold_sel(uv),
        .o_io_rail_voltage_sel(io_sel), .o_io_rail_en(io_en),
        .o_io_rail_discharge(io_dis), .o_proc_rail_voltage_code(code),
        .o_proc_rail_en(pr_en), .o_proc_rail_discharge(pr_dis),
        .o_motor_driver_en(motor), .o_wait_mode(wt), .o_lowpower_mode(lp));
    // Clock and hang guard
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [8:0] s, input logic [8:0] e);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic report_and_stop();
        if (error_cnt == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Reset with given straps, then reset values
    task automatic t_reset(input logic a, input logic b);
        @(negedge clk);
        rst = 1'b1;
        ios = a;
        prs = b;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        i_cvc_host.rd(8'h0C, d, h);
        chk(d, `CVC_IO_RESET_BASE | {7'h00, a});
        i_cvc_host.rd(8'h0D, d, h);
        chk(d, `CVC_PR_RESET_BASE | {3'h0, b, 4'h0});
        chk(code, {2'b11, b});
        chk(io_sel, {1'b1, a});
    endtask
    // Eight codes of both control registers, read back and applied
    task automatic t_codes();
        logic [7:0] v;
        for (int i = 0; i < 8; i++) begin
            v = {i[0], i[1:0], 3'b000, ~i[1:0]};
            i_cvc_host.wr(8'h0C, v);
            i_cvc_host.rd(8'h0C, d, h);
            chk(d, v);
            chk(forced_pwm, i[0]);
            chk(uv, i[1:0]);
            chk(io_sel, 2'(~i[1:0]));
            v = {1'b0, i[2:0], 2'b10, i[0], 1'b0};
            i_cvc_host.wr(8'h0D, v);
            i_cvc_host.rd(8'h0D, d, h);
            chk(d, v);
            chk(code, i[2:0]);
            chk(motor, i[0]);
        end
        i_cvc_host.wr(8'h0E, 8'hFF);
        i_cvc_host.rd(8'h0E, d, h);
        chk({h, d}, 9'h000);
        i_cvc_host.rd(8'h0D, d, h);
        chk({h, d}, 9'h17A);
    endtask
    // Sleep pin decoding with enable, select, core-off and discharge
    task automatic t_mode(input logic en, input logic sel, input logic off,
                          input logic ds);
        logic w, l;
        w = en & ~sel;
        l = en & sel;
        i_cvc_host.wr(8'h0C, {3'b000, sel, en, ds, 2'b10});
        i_cvc_host.wr(8'h0D, {off, 3'b111, 2'b01, 1'b0, ds});
        pin = 1'b1;
        repeat (4) @(negedge clk);
        chk(wt, w);
        chk(lp, l);
        chk(code, l ? 3'h1 : 3'h7);
        chk({io_en, io_dis}, {~w, w & ds});
        chk(pr_en, !(w | (l & off)));
        chk(pr_dis, (w | (l & off)) & ds);
        pin = 1'b0;
        repeat (4) @(negedge clk);
        chk({lp, code}, 4'h7);
    endtask
    // Main sequence
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        pin = 1'b0;
        ios = 1'b0;
        prs = 1'b0;
        t_reset(1'b1, 1'b0);
        t_reset(1'b0, 1'b1);
        t_codes();
        t_mode(1'b0, 1'b1, 1'b1, 1'b1);
        t_mode(1'b1, 1'b0, 1'b0, 1'b1);
        t_mode(1'b1, 1'b0, 1'b0, 1'b0);
        t_mode(1'b1, 1'b1, 1'b1, 1'b1);
        t_mode(1'b1, 1'b1, 1'b0, 1'b1);
        report_and_stop();
    end
endmodule // cvc_ctrl_test
bind cvc_ctrl cvc_checker i_cvc_checker (.*);
`default_nettype wire

// file: sim/cvc_host.sv
// Host model for the register strobe port
// Assumes the bench calls its tasks; drives after falling edges
`timescale 1ns/1ns
`default_nettype none
module cvc_host (
    input  wire logic       i_sys_clk,
    input  wire logic [7:0] i_reg_rdata,
    input  wire logic       i_reg_hit,
    output logic            o_reg_wr,
    output logic            o_reg_rd,
    output logic      [7:0] o_reg_addr,
    output logic      [7:0] o_reg_wdata
);
    // Idle bus at time zero
    initial begin
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_addr = 8'h00;
        o_reg_wdata = 8'h00;
    end
    // One write; released lines show the inverse of their last value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_sys_clk);
        o_reg_wr = 1'b1;
        o_reg_addr = a;
        o_reg_wdata = d;
        @(negedge i_sys_clk);
        o_reg_wr = 1'b0;
        o_reg_addr = ~a;
        o_reg_wdata = ~d;
    endtask
    // One read; answer taken one edge after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic h);
        @(negedge i_sys_clk);
        o_reg_rd = 1'b1;
        o_reg_addr = a;
        @(negedge i_sys_clk);
        o_reg_rd = 1'b0;
        o_reg_addr = ~a;
        @(posedge i_sys_clk);
        #1;
        d = i_reg_rdata;
        h = i_reg_hit;
    endtask
endmodule // cvc_host
`default_nettype wire
